// ===== design/mhpf_top.sv
// Host-side pin functions: clock out, flow control, multi-use pins and result stream.
`include "mhpf_defs.svh"
module mhpf_top
  import mhpf_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_nrst,
  // Register bus
  input wire mhpf_avm_req_t i_avm,
  output logic [31:0] o_avm_readdata,
  output logic o_avm_waitrequest,
  // Multi-use pins, index 0 is pin one
  input wire logic [3:0] i_pins,
  output mhpf_pins_t o_pins,
  output logic [3:0] o_analog_sel,
  // Clock output and flow control
  output logic o_divided_clock_output,
  output logic o_clear_to_send,
  input wire logic i_tx_room,
  // Modem core events and data
  input wire logic [7:0] i_cp_event,
  input wire logic [4:0] i_alert_event,
  input wire logic i_carrier_present,
  input wire logic i_frame_end,
  input wire logic i_ser2_tx_data,
  input wire logic i_modem_rx_valid,
  input wire logic [7:0] i_modem_rx_byte,
  input wire logic i_cid_valid,
  input wire logic [7:0] i_cid_byte,
  // Towards the host serial link and core
  output mhpf_host_byte_t o_host_byte,
  output logic o_secondary_serial_rx,
  output logic o_online,
  output logic o_sleep,
  output logic [7:0] o_modulation_sel
);

  ////////////////////////////////////////////////////////////////////////////////

  logic [4:0] div_r;
  mhpf_pin_mode_t mode_r [`MHPF_NPINS];
  logic [3:0] gpio_out_r;
  logic alert_r;
  logic cde_r;
  logic [7:0] cid_fmt_r;
  logic ser2_en_r;
  logic frame_end_receive_flag_sel_r;
  logic sleep_r;
  mhpf_state_t state_r;
  logic [3:0] pin_lvl;
  logic esc_prev_r;
  logic esc_rise;
  logic wr_take;
  logic alert_clr;
  logic alert_set;
  logic japan;
  logic [8:0] cp_char;
  logic [31:0] rd_nxt;
  mhpf_pins_t pins_nxt;

  function automatic logic wr_hit(input mhpf_avm_req_t req, input logic [7:0] ofs);
    wr_hit = req.write && req.byteenable[0] && (req.address == ofs);
  endfunction

  // Priority decode of progress events into one result character.
  function automatic logic [8:0] event_char(input logic [7:0] ev, input logic jp);
    event_char = 9'h000;
    if (ev[`MHPF_EV_CONNECT]) begin
      event_char = {1'h1, `MHPF_CH_CONNECT};
    end else if (ev[`MHPF_EV_NOCARRIER]) begin
      event_char = {1'h1, `MHPF_CH_NOCARRIER};
    end else if (ev[`MHPF_EV_BUSY]) begin
      event_char = {1'h1, `MHPF_CH_BUSY};
    end else if (ev[`MHPF_EV_RINGBACK]) begin
      event_char = {1'h1, `MHPF_CH_RINGBACK};
    end else if (ev[`MHPF_EV_DIALED]) begin
      event_char = {1'h1, `MHPF_CH_DIALED};
    end else if (ev[`MHPF_EV_TONE]) begin
      event_char = {1'h1, `MHPF_CH_TONE};
    end else if (jp && ev[`MHPF_EV_REVERSAL]) begin
      event_char = {1'h1, `MHPF_CH_REVERSAL};
    end else if (jp && ev[`MHPF_EV_MARK]) begin
      event_char = {1'h1, `MHPF_CH_MARK};
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Pin input synchronisers.

  genvar gi;
  generate
    for (gi = 0; gi < `MHPF_NPINS; gi++) begin : g_sync
      mhpf_pin_sync u_sync (
        .i_clk(i_clk),
        .i_nrst(i_nrst),
        .i_pin(i_pins[gi]),
        .o_level(pin_lvl[gi])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // Register bus: every access waits exactly one cycle, reads come from a flop.

  assign wr_take = i_avm.write && !o_avm_waitrequest;

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      o_avm_waitrequest <= 1'h1;
      o_avm_readdata <= 32'h00000000;
    end else if ((i_avm.read || i_avm.write) && o_avm_waitrequest) begin
      o_avm_waitrequest <= 1'h0;
      o_avm_readdata <= rd_nxt;
    end else begin
      o_avm_waitrequest <= 1'h1;
    end
  end

  always_comb begin
    rd_nxt = 32'h00000000;
    case (i_avm.address)
      `MHPF_OFS_CLKDIV: rd_nxt[4:0] = div_r;
      `MHPF_OFS_PINMODE: begin
        for (int k = 0; k < `MHPF_NPINS; k++) begin
          rd_nxt[k * `MHPF_MODE_W +: `MHPF_MODE_W] = mode_r[k];
        end
      end
      `MHPF_OFS_GPIO_OUT: rd_nxt[3:0] = gpio_out_r;
      `MHPF_OFS_GPIO_IN: rd_nxt[3:0] = pin_lvl;
      `MHPF_OFS_ALERT: rd_nxt[`MHPF_ST_ALERT] = alert_r;
      `MHPF_OFS_CD_CTRL: rd_nxt[`MHPF_CDE_BIT] = cde_r;
      `MHPF_OFS_CID_FMT: rd_nxt[7:0] = cid_fmt_r;
      `MHPF_OFS_MOD_SEL: rd_nxt[7:0] = o_modulation_sel;
      `MHPF_OFS_MISC: begin
        rd_nxt[`MHPF_MISC_SER2_EN] = ser2_en_r;
        rd_nxt[`MHPF_MISC_FRAME_END_RECEIVE_FLAG_SEL] = frame_end_receive_flag_sel_r;
        rd_nxt[`MHPF_MISC_SLEEP] = sleep_r;
      end
      `MHPF_OFS_STATUS: begin
        rd_nxt[`MHPF_ST_ONLINE] = (state_r == MHPF_ONLINE);
        rd_nxt[`MHPF_ST_SLEEP] = sleep_r;
        rd_nxt[`MHPF_ST_ALERT] = alert_r;
      end
      default: rd_nxt = 32'h00000000;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Control registers.

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      div_r <= `MHPF_CLKDIV_RST;
      gpio_out_r <= 4'h0;
      cde_r <= 1'h0;
      cid_fmt_r <= `MHPF_BYTE_RST;
      o_modulation_sel <= `MHPF_BYTE_RST;
      ser2_en_r <= 1'h0;
      frame_end_receive_flag_sel_r <= 1'h0;
      sleep_r <= 1'h0;
      for (int k = 0; k < `MHPF_NPINS; k++) begin
        mode_r[k] <= MHPF_DIG_IN;
      end
    end else if (wr_take && i_avm.byteenable[0]) begin
      case (i_avm.address)
        `MHPF_OFS_CLKDIV: div_r <= i_avm.writedata[4:0];
        `MHPF_OFS_PINMODE: begin
          for (int k = 0; k < `MHPF_NPINS; k++) begin
            mode_r[k] <= mhpf_pin_mode_t'(i_avm.writedata[k * `MHPF_MODE_W +: `MHPF_MODE_W]);
          end
        end
        `MHPF_OFS_GPIO_OUT: gpio_out_r <= i_avm.writedata[3:0];
        `MHPF_OFS_CD_CTRL: cde_r <= i_avm.writedata[`MHPF_CDE_BIT];
        `MHPF_OFS_CID_FMT: cid_fmt_r <= i_avm.writedata[7:0];
        `MHPF_OFS_MOD_SEL: o_modulation_sel <= i_avm.writedata[7:0];
        `MHPF_OFS_MISC: begin
          ser2_en_r <= i_avm.writedata[`MHPF_MISC_SER2_EN];
          frame_end_receive_flag_sel_r <= i_avm.writedata[`MHPF_MISC_FRAME_END_RECEIVE_FLAG_SEL];
          sleep_r <= i_avm.writedata[`MHPF_MISC_SLEEP];
        end
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Sticky alert: a new event in the clearing cycle keeps the pin high.

  assign alert_clr = wr_take && wr_hit(i_avm, `MHPF_OFS_ALERT)
    && (i_avm.writedata[`MHPF_ALERT_CLR_HI:`MHPF_ALERT_CLR_LO] == `MHPF_ALERT_CLR_VAL);
  assign alert_set = (mode_r[3] == MHPF_SPECIAL) && (state_r == MHPF_ONLINE)
    && (|i_alert_event);

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      alert_r <= 1'h0;
    end else if (alert_set) begin
      alert_r <= 1'h1;
    end else if (alert_clr) begin
      alert_r <= 1'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Online state and the host result stream.

  assign esc_rise = (mode_r[2] == MHPF_SPECIAL) && pin_lvl[2] && !esc_prev_r;
  assign japan = (cid_fmt_r == `MHPF_CID_JAPAN);
  assign cp_char = event_char(i_cp_event, japan);

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      esc_prev_r <= 1'h0;
    end else begin
      esc_prev_r <= pin_lvl[2];
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      state_r <= MHPF_OFFLINE;
    end else begin
      case (state_r)
        MHPF_OFFLINE: begin
          if (cp_char == {1'h1, `MHPF_CH_CONNECT}) begin
            state_r <= MHPF_ONLINE;
          end
        end
        MHPF_ONLINE: begin
          if (esc_rise) begin
            state_r <= MHPF_OFFLINE;
          end
        end
        default: state_r <= MHPF_OFFLINE;
      endcase
    end
  end

  // Online, only core data pass; progress characters would corrupt the data stream.
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      o_host_byte <= '0;
    end else if (state_r == MHPF_ONLINE) begin
      o_host_byte.valid <= i_modem_rx_valid;
      o_host_byte.is_data <= 1'h1;
      o_host_byte.byte_val <= i_modem_rx_byte;
    end else if (cp_char[8]) begin
      o_host_byte.valid <= 1'h1;
      o_host_byte.is_data <= 1'h0;
      o_host_byte.byte_val <= cp_char[7:0];
    end else begin
      o_host_byte.valid <= i_cid_valid;
      o_host_byte.is_data <= 1'h0;
      o_host_byte.byte_val <= i_cid_byte;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Pin drivers.

  always_comb begin
    for (int k = 0; k < `MHPF_NPINS; k++) begin
      pins_nxt.oe[k] = (mode_r[k] == MHPF_DIG_OUT);
      pins_nxt.o[k] = gpio_out_r[k];
    end
    if (mode_r[3] == MHPF_SPECIAL) begin
      pins_nxt.oe[3] = 1'h1;
      pins_nxt.o[3] = alert_r;
    end
    if (cde_r) begin
      pins_nxt.oe[1] = 1'h1;
      pins_nxt.o[1] = !i_carrier_present;
    end else if ((mode_r[1] == MHPF_SPECIAL) && ser2_en_r) begin
      pins_nxt.oe[1] = 1'h1;
      pins_nxt.o[1] = i_ser2_tx_data;
    end
    if ((mode_r[0] == MHPF_SPECIAL) && frame_end_receive_flag_sel_r) begin
      pins_nxt.oe[0] = 1'h1;
      pins_nxt.o[0] = i_frame_end;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      o_pins <= '0;
      o_analog_sel <= 4'h0;
      o_secondary_serial_rx <= 1'h1;
    end else begin
      o_pins <= pins_nxt;
      for (int k = 0; k < `MHPF_NPINS; k++) begin
        o_analog_sel[k] <= (mode_r[k] == MHPF_ANALOG);
      end
      o_secondary_serial_rx <= ((mode_r[0] == MHPF_SPECIAL) && ser2_en_r && !frame_end_receive_flag_sel_r)
        ? pin_lvl[0] : 1'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Flow control, status outputs and clock output.

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      o_clear_to_send <= 1'h0;
      o_online <= 1'h0;
      o_sleep <= 1'h0;
    end else begin
      // Asleep, nothing can be taken from the serial input.
      o_clear_to_send <= i_tx_room && !sleep_r;
      o_online <= (state_r == MHPF_ONLINE);
      o_sleep <= sleep_r;
    end
  end

  // The one input clock is the whole timing reference, including the clock output.
  mhpf_clkdiv u_clkdiv (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_div(div_r),
    .o_clk_out(o_divided_clock_output)
  );

  ////////////////////////////////////////////////////////////////////////////////

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);

  sequence s_connect_seen;
    (state_r == MHPF_OFFLINE) && i_cp_event[`MHPF_EV_CONNECT];
  endsequence

  sequence s_connect_out;
    o_host_byte.valid && !o_host_byte.is_data && (o_host_byte.byte_val == `MHPF_CH_CONNECT);
  endsequence

  a_reset_defaults: assert property ($rose(i_nrst) |-> div_r == `MHPF_CLKDIV_RST
      && mode_r[3] == MHPF_DIG_IN && !sleep_r && !cde_r)
    else $error("control registers not at initial values after reset");
  a_cts_when_asleep: assert property (sleep_r |=> !o_clear_to_send)
    else $error("clear to send high while asleep");
  a_alert_raised: assert property (alert_set |=> alert_r ##1 o_pins.o[3])
    else $error("alert event did not raise alert pin");
  a_alert_sticky: assert property (alert_r && !alert_clr |=> alert_r)
    else $error("alert dropped without clearing write");
  a_escape_offline: assert property ((state_r == MHPF_ONLINE) && esc_rise
      |=> state_r == MHPF_OFFLINE ##1 !o_online)
    else $error("escape edge did not leave online mode");
  a_carrier_pin: assert property (cde_r |=> o_pins.oe[1]
      && (o_pins.o[1] == !$past(i_carrier_present)))
    else $error("carrier detect pin wrong");
  a_connect_data: assert property (s_connect_seen |=> s_connect_out ##0
      (state_r == MHPF_ONLINE) ##1 (!o_host_byte.valid || o_host_byte.is_data))
    else $error("connect character not followed by data mode");
  a_japan_reversal: assert property ((state_r == MHPF_OFFLINE) && japan
      && (i_cp_event == 8'h40) |=> o_host_byte.valid
      && (o_host_byte.byte_val == `MHPF_CH_REVERSAL))
    else $error("reversal character missing in Japanese format");
  a_tone_char: assert property ((state_r == MHPF_OFFLINE) && (i_cp_event == 8'h01)
      |=> o_host_byte.valid && (o_host_byte.byte_val == `MHPF_CH_TONE))
    else $error("tone character missing");

endmodule

// ===== shared/mhpf_defs.svh
// Offsets, field positions, reset values and character codes of the pin-function block.
`ifndef MHPF_DEFS_SVH
`define MHPF_DEFS_SVH

`define MHPF_OFS_CLKDIV 8'h00
`define MHPF_OFS_PINMODE 8'h04
`define MHPF_OFS_GPIO_OUT 8'h08
`define MHPF_OFS_GPIO_IN 8'h0c
`define MHPF_OFS_ALERT 8'h10
`define MHPF_OFS_CD_CTRL 8'h14
`define MHPF_OFS_CID_FMT 8'h18
`define MHPF_OFS_MOD_SEL 8'h1c
`define MHPF_OFS_MISC 8'h20
`define MHPF_OFS_STATUS 8'h24

`define MHPF_CLKDIV_RST 5'h07
`define MHPF_PINMODE_RST 8'h00
`define MHPF_BYTE_RST 8'h00
`define MHPF_MODE_W 2
`define MHPF_NPINS 4

`define MHPF_ALERT_CLR_HI 7
`define MHPF_ALERT_CLR_LO 6
`define MHPF_ALERT_CLR_VAL 2'h3
`define MHPF_CDE_BIT 7
`define MHPF_CID_JAPAN 8'h80
`define MHPF_MISC_SER2_EN 0
`define MHPF_MISC_FRAME_END_RECEIVE_FLAG_SEL 1
`define MHPF_MISC_SLEEP 2
`define MHPF_ST_ONLINE 0
`define MHPF_ST_SLEEP 1
`define MHPF_ST_ALERT 2

`define MHPF_EV_TONE 0
`define MHPF_EV_DIALED 1
`define MHPF_EV_RINGBACK 2
`define MHPF_EV_BUSY 3
`define MHPF_EV_NOCARRIER 4
`define MHPF_EV_CONNECT 5
`define MHPF_EV_REVERSAL 6
`define MHPF_EV_MARK 7

`define MHPF_CH_TONE 8'h74
`define MHPF_CH_DIALED 8'h2c
`define MHPF_CH_RINGBACK 8'h72
`define MHPF_CH_BUSY 8'h62
`define MHPF_CH_NOCARRIER 8'h4e
`define MHPF_CH_CONNECT 8'h63
`define MHPF_CH_REVERSAL 8'h66
`define MHPF_CH_MARK 8'h6d

`endif

// ===== shared/mhpf_pkg.sv
// Types shared by the pin-function block.
package mhpf_pkg;

  typedef enum logic [1:0] {
    MHPF_DIG_IN = 2'h0,
    MHPF_ANALOG = 2'h1,
    MHPF_DIG_OUT = 2'h2,
    MHPF_SPECIAL = 2'h3
  } mhpf_pin_mode_t;

  typedef enum logic {
    MHPF_OFFLINE = 1'h0,
    MHPF_ONLINE = 1'h1
  } mhpf_state_t;

  typedef struct packed {
    logic read;
    logic write;
    logic [7:0] address;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } mhpf_avm_req_t;

  typedef struct packed {
    logic [3:0] o;
    logic [3:0] oe;
  } mhpf_pins_t;

  typedef struct packed {
    logic valid;
    logic is_data;
    logic [7:0] byte_val;
  } mhpf_host_byte_t;

endpackage

// ===== design/mhpf_pin_sync.sv
// Three-stage synchroniser with agreement filter for one pin input.
module mhpf_pin_sync (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_nrst,
  // Pin level
  input wire logic i_pin,
  output logic o_level
);

  logic s1_r;
  logic s2_r;
  logic s3_r;

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      s1_r <= 1'h0;
      s2_r <= 1'h0;
      s3_r <= 1'h0;
    end else begin
      s1_r <= i_pin;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // The first stage is left alone; only stages two and three are compared.
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      o_level <= 1'h0;
    end else if (s2_r == s3_r) begin
      o_level <= s3_r;
    end
  end

endmodule

// ===== design/mhpf_clkdiv.sv
// Programmable clock output divider with glitch-free reload between non-zero settings.
`include "mhpf_defs.svh"
module mhpf_clkdiv (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_nrst,
  // Divider setting and clock out
  input wire logic [4:0] i_div,
  output logic o_clk_out
);

  logic [4:0] cnt_r;
  logic [4:0] act_r;
  logic [4:0] cnt_nxt;
  logic [5:0] half;
  logic at_end;

  assign at_end = (cnt_r == act_r);
  assign cnt_nxt = at_end ? 5'h00 : 5'(cnt_r + 5'h01);
  assign half = 6'((6'(act_r) + 6'h01) >> 1);

  // A new setting is taken only at a period end, so no runt pulse appears between non-zero settings.
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      cnt_r <= 5'h00;
      act_r <= `MHPF_CLKDIV_RST;
    end else begin
      cnt_r <= cnt_nxt;
      if (at_end) begin
        act_r <= i_div;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      o_clk_out <= 1'h0;
    end else begin
      // A setting of zero parks the output low.
      o_clk_out <= (act_r != 5'h00) && (6'(cnt_nxt) < half);
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);

  a_divided_clock_output_stopped: assert property (act_r == 5'h00 |=> !o_clk_out)
    else $error("clock output toggles with divider zero");
  a_div_at_boundary: assert property (!$stable(act_r) |-> $past(cnt_r) == $past(act_r))
    else $error("divider changed inside a period");
  a_period_start_high: assert property (
      (act_r != 5'h00) && at_end && (i_div != 5'h00) |=> o_clk_out)
    else $error("clock output not high at period start");

endmodule

// ===== test/mhpf_host_model.sv
// Host microcontroller model: resolves shared pins and measures the divided clock.
module mhpf_host_model
  import mhpf_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_nrst,
  // Pins as driven by the device and by the host
  input wire mhpf_pins_t i_dev_pins,
  input wire logic [3:0] i_host_drv,
  input wire logic i_clk_out,
  // Resolved pins and clock measurements
  output logic [3:0] o_pin_level,
  output logic [7:0] o_period,
  output logic [15:0] o_rises
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] cnt_r;
  logic last_r;
  // A pin shows the device value while it drives, else the host level.
  assign o_pin_level = (i_dev_pins.oe & i_dev_pins.o) | (~i_dev_pins.oe & i_host_drv);
  //////////////////////////////////////////////////////////////////////////////
  // Period is counted in system cycles between rising edges of the divided clock.
  always_ff @(posedge i_clk) begin
    last_r <= i_clk_out;
    if (!i_nrst) begin
      cnt_r <= 8'h00;
      o_period <= 8'h00;
      o_rises <= 16'h0000;
    end else if (i_clk_out && !last_r) begin
      o_period <= cnt_r + 8'h01;
      cnt_r <= 8'h00;
      o_rises <= o_rises + 16'h0001;
    end else begin
      cnt_r <= cnt_r + 8'h01;
    end
  end
endmodule

// ===== test/modem_host_pin_functions_bench.sv
// Self-checking bench for the host-side pin-function block.
`include "mhpf_defs.svh"
module modem_host_pin_functions_bench
  import mhpf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, nrst = 0, tx_room = 0, carrier = 0, frame_end = 0, ser2_tx = 0;
  logic rx_valid = 0, cid_valid = 0, cts, clk_out, ser2_rx, online, sleep;
  logic [7:0] cp_event = 0, rx_byte = 8'h55, cid_byte = 8'h41, mod_sel, period;
  logic [4:0] alert_event = 0;
  logic [3:0] host_drv = 0, pin_level, analog_sel;
  logic [15:0] rises;
  logic [31:0] rdata, q;
  logic wreq;
  mhpf_avm_req_t avm = '0;
  mhpf_pins_t pins;
  mhpf_host_byte_t hb;
  int bad_count = 0, n_compared = 0, cycles = 0;
  logic [7:0] prog [5] = '{`MHPF_CH_TONE, `MHPF_CH_DIALED, `MHPF_CH_RINGBACK,
    `MHPF_CH_BUSY, `MHPF_CH_NOCARRIER};
  logic [7:0] rst_ofs [9] = '{`MHPF_OFS_CLKDIV, `MHPF_OFS_PINMODE, `MHPF_OFS_GPIO_OUT,
    `MHPF_OFS_CD_CTRL, `MHPF_OFS_CID_FMT, `MHPF_OFS_MOD_SEL, `MHPF_OFS_MISC,
    `MHPF_OFS_STATUS, 8'h3c};
  mhpf_top dut (.i_clk(clk), .i_nrst(nrst), .i_avm(avm), .o_avm_readdata(rdata),
    .o_avm_waitrequest(wreq), .i_pins(pin_level), .o_pins(pins), .o_analog_sel(analog_sel),
    .o_divided_clock_output(clk_out), .o_clear_to_send(cts), .i_tx_room(tx_room),
    .i_cp_event(cp_event), .i_alert_event(alert_event), .i_carrier_present(carrier),
    .i_frame_end(frame_end), .i_ser2_tx_data(ser2_tx), .i_modem_rx_valid(rx_valid),
    .i_modem_rx_byte(rx_byte), .i_cid_valid(cid_valid), .i_cid_byte(cid_byte),
    .o_host_byte(hb), .o_secondary_serial_rx(ser2_rx), .o_online(online),
    .o_sleep(sleep), .o_modulation_sel(mod_sel));
  mhpf_host_model host (.i_clk(clk), .i_nrst(nrst), .i_dev_pins(pins),
    .i_host_drv(host_drv), .i_clk_out(clk_out), .o_pin_level(pin_level),
    .o_period(period), .o_rises(rises));
  initial begin
    forever #50 clk = ~clk;
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // The request is held until waitrequest is sampled low; the bench never assumes a latency.
  // A hung slave is ended only by the cycle ceiling below, which counts it as a mismatch.
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    avm <= '{read: !wr, write: wr, address: a, writedata: d, byteenable: 4'hf};
    do begin
      @(posedge clk);
    end while (wreq !== 1'b0);
    q = rdata;
    avm <= '0;
  endtask
  task automatic pulse(input logic [7:0] ev, input logic cv, input logic rv);
    @(posedge clk);
    cp_event <= ev;
    cid_valid <= cv;
    rx_valid <= rv;
    @(posedge clk);
    cp_event <= 8'h00;
    cid_valid <= 1'b0;
    rx_valid <= 1'b0;
    #1;
  endtask
  task automatic print_verdict();
    $display("compared %0d bad %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      print_verdict();
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    tx_room <= 1'b1;
    foreach (rst_ofs[i]) begin
      bus(1'b0, rst_ofs[i], 32'h0);
      check("reset value", q, (i == 0) ? 32'h7 : 32'h0);
    end
    repeat (30) @(posedge clk);
    check("default period", 32'(period), 32'h8);
    check("cts ready", 32'(cts), 32'h1);
    tx_room <= 1'b0;
    repeat (3) @(posedge clk);
    check("cts full", 32'(cts), 32'h0);
    tx_room <= 1'b1;
    bus(1'b1, `MHPF_OFS_CLKDIV, 32'h2);
    repeat (40) @(posedge clk);
    check("period n2", 32'(period), 32'h3);
    bus(1'b1, `MHPF_OFS_CLKDIV, 32'h1f);
    repeat (100) @(posedge clk);
    check("period n31", 32'(period), 32'h20);
    bus(1'b1, `MHPF_OFS_CLKDIV, 32'h0);
    repeat (70) @(posedge clk);
    q = 32'(rises);
    repeat (40) @(posedge clk);
    check("stopped clock", 32'(rises), q);
    check("stopped level", 32'(clk_out), 32'h0);
    bus(1'b1, `MHPF_OFS_MOD_SEL, 32'h5a);
    @(posedge clk);
    check("modulation", 32'(mod_sel), 32'h5a);
    // Pin one analog, pin two digital output driving high.
    bus(1'b1, `MHPF_OFS_GPIO_OUT, 32'h2);
    bus(1'b1, `MHPF_OFS_PINMODE, 32'h09);
    host_drv <= 4'h8;
    repeat (8) @(posedge clk);
    check("analog sel", 32'(analog_sel), 32'h1);
    check("pin two out", 32'({pins.oe[1], pins.o[1]}), 32'h3);
    bus(1'b0, `MHPF_OFS_GPIO_IN, 32'h0);
    check("pin four in", q & 32'h8, 32'h8);
    bus(1'b1, `MHPF_OFS_MISC, 32'h1);
    bus(1'b1, `MHPF_OFS_PINMODE, 32'h0f);
    for (int v = 0; v < 2; v++) begin
      ser2_tx <= v[0];
      host_drv[0] <= v[0];
      repeat (8) @(posedge clk);
      check("ser2 tx", 32'({pins.oe[1], pins.o[1]}), 32'(2 + v));
      check("ser2 rx", 32'(ser2_rx), 32'(v));
    end
    bus(1'b1, `MHPF_OFS_MISC, 32'h3);
    frame_end <= 1'b1;
    repeat (2) @(posedge clk);
    check("frame end pin", 32'({pins.oe[0], pins.o[0]}), 32'h3);
    check("rx idle in frame mode", 32'(ser2_rx), 32'h1);
    frame_end <= 1'b0;
    bus(1'b1, `MHPF_OFS_CD_CTRL, 32'h80);
    for (int v = 0; v < 2; v++) begin
      carrier <= !v[0];
      repeat (3) @(posedge clk);
      check("carrier pin", 32'({pins.oe[1], pins.o[1]}), 32'(2 + v));
    end
    bus(1'b1, `MHPF_OFS_CID_FMT, 32'(`MHPF_CID_JAPAN));
    pulse(8'h40, 1'b0, 1'b0);
    check("reversal", 32'(hb), 32'h200 | `MHPF_CH_REVERSAL);
    pulse(8'h80, 1'b0, 1'b0);
    check("mark", 32'(hb), 32'h200 | `MHPF_CH_MARK);
    pulse(8'h00, 1'b1, 1'b0);
    check("cid data", 32'(hb), 32'h241);
    bus(1'b1, `MHPF_OFS_CID_FMT, 32'h0);
    pulse(8'h40, 1'b0, 1'b0);
    check("no reversal", 32'(hb.valid), 32'h0);
    foreach (prog[i]) begin
      pulse(8'h01 << i, 1'b0, 1'b0);
      check("progress", 32'(hb), 32'h200 | prog[i]);
    end
    pulse(8'h20, 1'b0, 1'b0);
    check("connect", 32'(hb), 32'h200 | `MHPF_CH_CONNECT);
    pulse(8'h00, 1'b0, 1'b1);
    check("modem data", 32'(hb), 32'h355);
    check("online", 32'(online), 32'h1);
    pulse(8'h01, 1'b0, 1'b0);
    check("online char", 32'(hb.valid), 32'h0);
    bus(1'b1, `MHPF_OFS_PINMODE, 32'hf0);
    repeat (2) @(posedge clk);
    check("alert idle", 32'({pins.oe[3], pins.o[3]}), 32'h2);
    for (int b = 0; b < 5; b++) begin
      @(posedge clk);
      alert_event <= 5'h01 << b;
      @(posedge clk);
      alert_event <= 5'h00;
      repeat (6) @(posedge clk);
      check("alert set", 32'(pins.o[3]), 32'h1);
      bus(1'b1, `MHPF_OFS_ALERT, 32'h80);
      check("alert kept", 32'(pins.o[3]), 32'h1);
      bus(1'b1, `MHPF_OFS_ALERT, 32'hc0);
      repeat (2) @(posedge clk);
      check("alert clear", 32'(pins.o[3]), 32'h0);
    end
    host_drv[2] <= 1'b1;
    repeat (10) @(posedge clk);
    check("escape", 32'(online), 32'h0);
    bus(1'b1, `MHPF_OFS_MISC, 32'h4);
    bus(1'b0, `MHPF_OFS_STATUS, 32'h0);
    check("asleep", q & 32'h2, 32'h2);
    check("cts asleep", 32'(cts), 32'h0);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    check("woken", 32'(sleep), 32'h0);
    bus(1'b0, `MHPF_OFS_PINMODE, 32'h0);
    check("pinmode again", q, 32'h0);
    bus(1'b0, `MHPF_OFS_CLKDIV, 32'h0);
    check("divider again", q, 32'h7);
    repeat (30) @(posedge clk);
    check("period again", 32'(period), 32'h8);
    print_verdict();
  end
endmodule
